// ---- hw/atcir_regs.sv ----
// Notes on behaviour
// R1: selector 00 leaves user buffers untouched
// R2: selector 01 loads buffers from host only
// R3: selector 10 loads buffers from receiver copy
// R4: selector 11: first ten bytes host, rest receiver
// R5: validity bit from control bit when cleared
// R6: validity passes from receiver through one register, one cycle of latency
// R7: transfer done flag set when enabled, unmasked
// R8: transfer done drives interrupt and summary flag
// R9: slip flag set on detected slip when unmasked
// R10: slip select bit picks slip or block start
// R11: slip flag drives interrupt and summary flag
// R12: transfer done mask zero blocks, one enables
// R13: slip mask zero blocks, one enables
// R14: status read only, bits 0 and 1
// R15: two-bit trigger mode per source
// R16: status read clears flags, releases interrupt
`timescale 1ns/10ps
`default_nettype none
`include "atcir_params.svh"
module atcir_regs
    import atcir_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // control bits held elsewhere in the device
    input wire logic i_validity_ctrl,
    input wire logic i_transfer_disable_bit,
    input wire logic i_slip_source_select,
    // transmitter and receiver events
    input wire logic i_transfer_done,
    input wire logic i_async_slip,
    input wire logic i_block_start,
    input wire logic i_rx_validity,
    // user-access buffer load steering
    input wire logic [7:0] i_buf_byte_idx,
    output logic o_buf_load_en,
    output logic o_buf_from_host,
    // validity and interrupt
    output logic o_tx_validity,
    output logic o_tx_summary,
    output logic o_int_n
);
    import atcir_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] ctrl3_q, ctrl3_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] mode_q, mode_d;
    logic done_flag_q, done_flag_d;
    logic slip_flag_q, slip_flag_d;
    logic done_prev_q, slip_prev_q;
    logic [7:0] rdata_q, rdata_d;
    logic load_q, load_d, host_q, host_d, val_q, val_d, summ_q, summ_d, int_n_q, int_n_d;
    atcir_src_t src;
    logic slip_raw;
    logic done_hit, slip_hit;
    logic clr_stat;

    // trigger on edge or level per selected mode
    function automatic logic trig_hit(input atcir_trig_t m, input logic cur, input logic prev);
        logic h;
        h = 1'b0;
        case (m)
            ATCIR_TRIG_RISE: h = cur & ~prev;
            ATCIR_TRIG_FALL: h = ~cur & prev;
            ATCIR_TRIG_LEVEL: h = cur;
            default: h = 1'b0;
        endcase
        return h;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        src = atcir_src_t'(ctrl3_q[`ATCIR_BIT_CUS_LO +: 2]);
        // R10: slip source choice
        slip_raw = i_slip_source_select ? i_block_start : i_async_slip;
        // R15: trigger mode select
        done_hit = trig_hit(atcir_trig_t'(mode_q[`ATCIR_MODE_DONE_LO +: 2]), i_transfer_done, done_prev_q);
        slip_hit = trig_hit(atcir_trig_t'(mode_q[`ATCIR_MODE_SLIP_LO +: 2]), slip_raw, slip_prev_q);
        clr_stat = i_reg_rd && (i_reg_addr == `ATCIR_OFS_STATUS);
        ctrl3_d = ctrl3_q;
        mask_d = mask_q;
        mode_d = mode_q;
        if (i_reg_wr)
        begin
            if (i_reg_addr == `ATCIR_OFS_CTRL3)
                ctrl3_d = {5'h00, i_reg_wdata[2:0]};
            else if (i_reg_addr == `ATCIR_OFS_MASK)
                mask_d = {6'h00, i_reg_wdata[1:0]};
            else if (i_reg_addr == `ATCIR_OFS_MODE)
                mode_d = {4'h0, i_reg_wdata[3:0]};
        end
        // R16: read clears, set wins over clear
        done_flag_d = clr_stat ? 1'b0 : done_flag_q;
        slip_flag_d = clr_stat ? 1'b0 : slip_flag_q;
        // R7: R12: transfer done gated by enable and mask
        if (done_hit && !i_transfer_disable_bit && mask_q[`ATCIR_BIT_DONE])
            done_flag_d = 1'b1;
        // R9: R13: slip gated by mask
        if (slip_hit && mask_q[`ATCIR_BIT_SLIP])
            slip_flag_d = 1'b1;
        // R8: R11: summary and interrupt from flags
        summ_d = done_flag_d | slip_flag_d;
        int_n_d = ~summ_d;
        // R1: R2: R3: R4: buffer load steering
        case (src)
            ATCIR_SRC_NONE:
            begin
                load_d = 1'b0;
                host_d = 1'b0;
            end
            ATCIR_SRC_HOST:
            begin
                load_d = 1'b1;
                host_d = 1'b1;
            end
            ATCIR_SRC_RECV:
            begin
                load_d = 1'b1;
                host_d = 1'b0;
            end
            default:
            begin
                load_d = 1'b1;
                host_d = i_buf_byte_idx < `ATCIR_HOST_BYTES;
            end
        endcase
        // R5: R6: validity source
        val_d = ctrl3_q[`ATCIR_BIT_VALSRC] ? i_rx_validity : i_validity_ctrl;
        // R14: readback, status read only
        rdata_d = 8'h00;
        if (i_reg_addr == `ATCIR_OFS_CTRL3)
            rdata_d = ctrl3_q;
        else if (i_reg_addr == `ATCIR_OFS_STATUS)
            rdata_d = {6'h00, slip_flag_q, done_flag_q};
        else if (i_reg_addr == `ATCIR_OFS_MASK)
            rdata_d = mask_q;
        else if (i_reg_addr == `ATCIR_OFS_MODE)
            rdata_d = mode_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl3_q <= `ATCIR_RST_CTRL3;
            mask_q <= `ATCIR_RST_MASK;
            mode_q <= `ATCIR_RST_MODE;
            done_flag_q <= 1'b0;
            slip_flag_q <= 1'b0;
            done_prev_q <= 1'b0;
            slip_prev_q <= 1'b0;
            rdata_q <= 8'h00;
            load_q <= 1'b0;
            host_q <= 1'b0;
            val_q <= 1'b0;
            summ_q <= 1'b0;
            int_n_q <= 1'b1;
        end
        else
        begin
            ctrl3_q <= ctrl3_d;
            mask_q <= mask_d;
            mode_q <= mode_d;
            done_flag_q <= done_flag_d;
            slip_flag_q <= slip_flag_d;
            done_prev_q <= i_transfer_done;
            slip_prev_q <= slip_raw;
            rdata_q <= rdata_d;
            load_q <= load_d;
            host_q <= host_d;
            val_q <= val_d;
            summ_q <= summ_d;
            int_n_q <= int_n_d;
        end
    end

    // outputs straight from flops
    assign o_reg_rdata = rdata_q;
    assign o_buf_load_en = load_q;
    assign o_buf_from_host = host_q;
    assign o_tx_validity = val_q;
    assign o_tx_summary = summ_q;
    assign o_int_n = int_n_q;
endmodule
`default_nettype wire

// ---- hw/atcir_params.svh ----
`ifndef ATCIR_PARAMS_SVH
`define ATCIR_PARAMS_SVH
// register indices on the internal register port
`define ATCIR_OFS_CTRL3 8'h09
`define ATCIR_OFS_STATUS 8'h0a
`define ATCIR_OFS_MASK 8'h0b
`define ATCIR_OFS_MODE 8'h0c
// field positions
`define ATCIR_BIT_CUS_LO 0
`define ATCIR_BIT_VALSRC 2
`define ATCIR_BIT_DONE 0
`define ATCIR_BIT_SLIP 1
`define ATCIR_MODE_DONE_LO 0
`define ATCIR_MODE_SLIP_LO 2
// reset values
`define ATCIR_RST_CTRL3 8'h00
`define ATCIR_RST_MASK 8'h00
`define ATCIR_RST_MODE 8'h00
// byte count of the host-owned region in split mode
`define ATCIR_HOST_BYTES 8'h0a
`endif

// ---- hw/atcir_pkg.sv ----
package atcir_pkg;
    // channel/user buffer source
    typedef enum logic [1:0] {
        ATCIR_SRC_NONE,
        ATCIR_SRC_HOST,
        ATCIR_SRC_RECV,
        ATCIR_SRC_SPLIT
    } atcir_src_t;
    // interrupt trigger modes
    typedef enum logic [1:0] {
        ATCIR_TRIG_RISE,
        ATCIR_TRIG_FALL,
        ATCIR_TRIG_LEVEL,
        ATCIR_TRIG_RSVD
    } atcir_trig_t;
endpackage

// ---- tb/atcir_regs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module atcir_regs_chk (
    // watched ports
    input wire logic i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_transfer_disable_bit, i_slip_source_select,
    input wire logic i_validity_ctrl, i_transfer_done, i_async_slip, i_block_start, i_rx_validity,
    input wire logic [7:0] i_reg_addr, i_reg_wdata, i_buf_byte_idx,
    input wire logic o_buf_load_en, o_buf_from_host, o_tx_validity, o_tx_summary, o_int_n
);
    logic [7:0] c3_q, mk_q, md_q;
    logic quiet;
    assign quiet = !i_transfer_done && !i_async_slip && !i_block_start;
    // shadow copies of the writable registers
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            {c3_q, mk_q, md_q} <= 24'h000000;
        else if (i_reg_wr)
        begin
            if (i_reg_addr == 8'h09) c3_q <= i_reg_wdata;
            if (i_reg_addr == 8'h0b) mk_q <= i_reg_wdata;
            if (i_reg_addr == 8'h0c) md_q <= i_reg_wdata;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_int_summary: assert property (o_int_n != o_tx_summary)
        else $error("interrupt not tied to summary");
    chk_valid_src: assert property ($past(i_rst_n) |-> o_tx_validity ==
        ($past(c3_q[2]) ? $past(i_rx_validity) : $past(i_validity_ctrl))) else $error("validity source wrong");
    chk_load_none: assert property ($past(i_rst_n) |-> o_buf_load_en == ($past(c3_q[1:0]) != 2'h0))
        else $error("load enable wrong");
    chk_host_split: assert property ($past(i_rst_n) && $past(c3_q[1:0]) != 2'h0 |-> o_buf_from_host ==
        ($past(c3_q[1:0]) == 2'h1 || ($past(c3_q[1:0]) == 2'h3 && $past(i_buf_byte_idx) < 8'h0a)))
        else $error("byte source wrong");
    chk_mask_block: assert property (o_int_n && mk_q[1:0] == 2'h0 |=> o_int_n)
        else $error("masked event interrupted");
    chk_done_rise: assert property ($past(i_rst_n) && $rose(i_transfer_done) && mk_q[0] &&
        md_q[1:0] == 2'h0 && !i_transfer_disable_bit |=> !o_int_n) else $error("transfer done lost");
    chk_slip_rise: assert property ($past(i_rst_n) && $stable(i_slip_source_select) && mk_q[1] &&
        $rose(i_slip_source_select ? i_block_start : i_async_slip) && md_q[3:2] == 2'h0 |=> !o_int_n)
        else $error("slip event lost");
    chk_read_clear: assert property (quiet[*2] ##1 (quiet && i_reg_rd && i_reg_addr == 8'h0a)
        ##1 quiet[*2] |-> o_int_n) else $error("status read did not release");
    cover property ($rose(i_transfer_done) && mk_q[0]);
    cover property (!o_int_n);
    cover property (i_reg_rd && i_reg_addr == 8'h0a && !o_int_n);
endmodule
bind atcir_regs atcir_regs_chk atcir_regs_chk_i (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_rd,
    .i_transfer_disable_bit, .i_slip_source_select, .i_validity_ctrl, .i_transfer_done, .i_async_slip,
    .i_block_start, .i_rx_validity, .i_reg_addr, .i_reg_wdata, .i_buf_byte_idx, .o_buf_load_en,
    .o_buf_from_host, .o_tx_validity, .o_tx_summary, .o_int_n);
`default_nettype wire

// ---- tb/test_atcir_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_atcir_regs;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, rd_seen = 1'b0;
    logic i_validity_ctrl = 1'b0, i_transfer_disable_bit = 1'b0, i_slip_source_select = 1'b0;
    logic i_transfer_done = 1'b0, i_async_slip = 1'b0, i_block_start = 1'b0, i_rx_validity = 1'b0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_buf_byte_idx = 8'h00, o_reg_rdata;
    logic o_buf_load_en, o_buf_from_host, o_tx_validity, o_tx_summary, o_int_n;
    logic [7:0] exp_q[$];
    logic [7:0] rst_ofs [5] = '{8'h09, 8'h0b, 8'h0c, 8'h05, 8'h0a};
    logic [31:0] seed = 32'h45;
    int error_cnt = 0, checks_done = 0;
    atcir_regs atcir_regs_i (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .i_validity_ctrl, .i_transfer_disable_bit, .i_slip_source_select, .i_transfer_done, .i_async_slip,
        .i_block_start, .i_rx_validity, .i_buf_byte_idx, .o_buf_load_en, .o_buf_from_host, .o_tx_validity,
        .o_tx_summary, .o_int_n);
    always #2 i_clk = ~i_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // random validity bits and byte index
    always @(negedge i_clk)
    begin
        seed = xs(seed);
        {i_validity_ctrl, i_rx_validity, i_buf_byte_idx} = {seed[1:0], 3'h0, seed[12:8]};
    end
    task automatic cmp(input logic [7:0] e);
        checks_done++;
        if (o_reg_rdata !== e)
        begin
            error_cnt++;
            $display("[FAIL] o_reg_rdata expected %h seen %h", e, o_reg_rdata);
        end
    endtask
    // note which edge took a read, check the settled readback half a cycle later
    always @(posedge i_clk)
    begin
        rd_seen <= i_reg_rd;
    end
    always @(negedge i_clk)
    begin
        if (rd_seen && exp_q.size() > 0) cmp(exp_q.pop_front());
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, !w, a, d};
        if (!w) exp_q.push_back(d);
        @(negedge i_clk);
        {i_reg_wr, i_reg_rd} = 2'h0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge i_clk);
        s = 1'b1;
        repeat (2) @(negedge i_clk);
        s = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        // reset values, unmapped index, read-only status
        foreach (rst_ofs[k]) acc(1'b0, rst_ofs[k], 8'h00);
        acc(1'b1, 8'h0a, 8'h03);
        acc(1'b0, 8'h0a, 8'h00);
        acc(1'b1, 8'h0b, 8'hff);
        acc(1'b0, 8'h0b, 8'h03);
        $display("register test done");
        // every selector with both validity sources
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b1, 8'h09, {5'h1f, i[2:0]});
            acc(1'b0, 8'h09, {5'h00, i[2:0]});
            repeat (20) @(negedge i_clk);
        end
        $display("source test done");
        pulse(i_transfer_done);
        acc(1'b0, 8'h0a, 8'h01);
        acc(1'b0, 8'h0a, 8'h00);
        i_slip_source_select = 1'b1;
        pulse(i_async_slip);
        pulse(i_block_start);
        acc(1'b0, 8'h0a, 8'h02);
        i_transfer_disable_bit = 1'b1;
        pulse(i_transfer_done);
        acc(1'b0, 8'h0a, 8'h00);
        i_transfer_disable_bit = 1'b0;
        acc(1'b1, 8'h0b, 8'h00);
        pulse(i_transfer_done);
        pulse(i_block_start);
        acc(1'b0, 8'h0a, 8'h00);
        // falling, level and reserved trigger modes
        acc(1'b1, 8'h0c, 8'h01);
        acc(1'b1, 8'h0b, 8'h03);
        pulse(i_transfer_done);
        acc(1'b0, 8'h0a, 8'h01);
        acc(1'b1, 8'h0c, 8'h08);
        pulse(i_block_start);
        acc(1'b0, 8'h0a, 8'h02);
        acc(1'b1, 8'h0c, 8'h0f);
        pulse(i_transfer_done);
        pulse(i_block_start);
        acc(1'b0, 8'h0a, 8'h00);
        $display("event test done");
        repeat (3) @(negedge i_clk);
        give_verdict;
    end
    // cut a hang short far past the expected run
    initial
    begin
        #20000;
        error_cnt++;
        give_verdict;
    end
endmodule
`default_nettype wire
